/* File: src/spipot_pkg.sv */
package spipot_pkg;

    // ****************************************************************
    // Command byte layout
    // ****************************************************************
    localparam int        LOC_W       = 4;
    localparam int        DATA_W      = 9;
    localparam int        CMD_BITS    = 16;
    localparam logic [3:0] POS_COMMAND_ERROR_FLAG = 4'h6;
    localparam logic [3:0] POS_UPPER  = 4'h7;
    localparam logic [3:0] POS_LOCOP  = 4'h5;
    localparam logic [3:0] POS_SHORT  = 4'h7;
    localparam logic [3:0] POS_LONG   = 4'hf;

    // ****************************************************************
    // Operation field codes
    // ****************************************************************
    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_INC   = 2'h1;
    localparam logic [1:0] OP_DEC   = 2'h2;
    localparam logic [1:0] OP_READ  = 2'h3;

    // ****************************************************************
    // Locations
    // ****************************************************************
    localparam logic [3:0] LOC_WIPER0    = 4'h0;
    localparam logic [3:0] LOC_WIPER1    = 4'h1;
    localparam logic [3:0] LOC_NV_WIPER0 = 4'h2;
    localparam logic [3:0] LOC_NV_WIPER1 = 4'h3;
    localparam logic [3:0] LOC_TERM_CTRL = 4'h4;
    localparam logic [3:0] LOC_STATUS    = 4'h5;
    localparam logic [3:0] LOC_LAST      = 4'hf;

    // ****************************************************************
    // Reset values and limits
    // ****************************************************************
    localparam logic [8:0] WIPER_RESET = 9'h080;
    localparam logic [8:0] MEM_RESET   = 9'h000;
    localparam logic [8:0] WIPER_FULL  = 9'h100;
    localparam logic [8:0] WIPER_ZERO  = 9'h000;

    typedef struct packed {
        logic [3:0] location_field;
        logic [1:0] operation_field;
        logic       raised;
        logic [8:0] data;
    } spipot_cmd_t;

endpackage : spipot_pkg

/* File: src/spipot_core.sv */
module spipot_core (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic       sck_i,
    input  wire logic       sdi_i,
    input  wire logic       select_n_i,
    input  wire logic       raised_select_level_i,
    output logic            sdo_o,
    output logic            sdo_oe_o,
    output logic            spi_mode_o,
    output logic [8:0]      wiper0_o,
    output logic [8:0]      wiper1_o,
    output logic            wiper0_protect_bit_o,
    output logic            wiper1_protect_bit_o,
    output logic            write_protect_o,
    output logic            nv_write_o,
    output logic [3:0]      nv_write_addr_o
);

    // ****************************************************************
    // Link domain: frame control
    // ****************************************************************
    logic        select_idle;
    logic        frame_rst;
    logic [3:0]  pos;
    logic [6:0]  shift;
    logic [3:0]  cur_loc;
    logic [1:0]  cur_op;
    logic        cur_valid;
    logic        upper;
    logic        err;
    logic        nv_written;
    logic [8:0]  rd_word;
    logic        done;
    logic [1:0]  op_now;
    logic [3:0]  loc_now;
    logic        valid_now;

    logic [8:0]  mem [16];
    logic        wl0;
    logic        wl1;
    logic        wp;
    logic        commit_tgl;
    spipot_pkg::spipot_cmd_t last_cmd;

    // Select idle only when low level absent and no raised level
    assign select_idle = select_n_i & ~raised_select_level_i;
    assign frame_rst   = rst_i | select_idle;

    assign loc_now = shift[4:1];
    assign op_now  = {shift[0], sdi_i};

    function automatic logic is_nv(input logic [3:0] loc);
        is_nv = (loc != spipot_pkg::LOC_WIPER0) &&
                (loc != spipot_pkg::LOC_WIPER1) &&
                (loc != spipot_pkg::LOC_TERM_CTRL) &&
                (loc != spipot_pkg::LOC_STATUS);
    endfunction

    function automatic logic combo_ok(input logic [3:0] loc,
                                      input logic [1:0] op,
                                      input logic       hv);
        logic rw;
        rw = (op == spipot_pkg::OP_READ) || (op == spipot_pkg::OP_WRITE);
        case (loc)
            spipot_pkg::LOC_WIPER0,
            spipot_pkg::LOC_WIPER1:    combo_ok = 1'b1;
            spipot_pkg::LOC_NV_WIPER0,
            spipot_pkg::LOC_NV_WIPER1,
            spipot_pkg::LOC_LAST:      combo_ok = rw | hv;
            spipot_pkg::LOC_STATUS:    combo_ok = (op == spipot_pkg::OP_READ);
            default:                   combo_ok = rw;
        endcase
    endfunction

    // A write to a nonvolatile spot poisons the rest of the frame
    assign valid_now = combo_ok(loc_now, op_now, raised_select_level_i) &
                       ~nv_written;

    // Command ends on byte 1 for inc/dec, byte 2 for read/write
    assign done = ((pos == spipot_pkg::POS_SHORT) &&
                   (cur_op == spipot_pkg::OP_INC ||
                    cur_op == spipot_pkg::OP_DEC)) ||
                  (pos == spipot_pkg::POS_LONG);

    always_ff @(posedge sck_i or posedge frame_rst) begin
        if (frame_rst) begin
            pos   <= 4'h0;
            shift <= 7'h00;
        end else begin
            shift <= {shift[5:0], sdi_i};
            pos   <= done ? 4'h0 : pos + 4'h1;
        end
    end

    always_ff @(posedge sck_i or posedge frame_rst) begin
        if (frame_rst) begin
            cur_loc   <= 4'h0;
            cur_op    <= spipot_pkg::OP_WRITE;
            cur_valid <= 1'b0;
            rd_word   <= 9'h000;
            upper     <= 1'b0;
        end else if (pos == spipot_pkg::POS_LOCOP) begin
            cur_loc   <= loc_now;
            cur_op    <= op_now;
            cur_valid <= valid_now;
            rd_word   <= mem[loc_now];
        end else if (pos == spipot_pkg::POS_UPPER) begin
            upper     <= sdi_i;
        end
    end

    always_ff @(posedge sck_i or posedge frame_rst) begin
        if (frame_rst) begin
            err        <= 1'b0;
            nv_written <= 1'b0;
        end else begin
            if (pos == spipot_pkg::POS_LOCOP && !valid_now) begin
                err <= 1'b1;
            end
            if (done && cur_valid && !err &&
                cur_op == spipot_pkg::OP_WRITE && is_nv(cur_loc)) begin
                nv_written <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Link domain: serial output on the falling edge
    // ****************************************************************
    always_ff @(negedge sck_i or posedge frame_rst) begin
        if (frame_rst) begin
            sdo_o <= 1'b1;
        end else if (pos == spipot_pkg::POS_COMMAND_ERROR_FLAG) begin
            sdo_o <= cur_valid & ~err;
        end else if (cur_op == spipot_pkg::OP_READ && cur_valid && !err &&
                     pos >= spipot_pkg::POS_UPPER) begin
            sdo_o <= rd_word[4'(spipot_pkg::POS_LONG - pos)];
        end else begin
            sdo_o <= 1'b1;
        end
    end

    // ****************************************************************
    // Link domain: storage, only on a whole valid command
    // ****************************************************************
    // Not cleared by select so the handoff to ref_clk survives frame end
    logic commit;
    logic hv_op;
    assign commit = done && cur_valid && !err && !nv_written;
    assign hv_op  = raised_select_level_i &&
                    (cur_loc == spipot_pkg::LOC_NV_WIPER0 ||
                     cur_loc == spipot_pkg::LOC_NV_WIPER1 ||
                     cur_loc == spipot_pkg::LOC_LAST);

    logic       locked;
    logic [8:0] next_value;
    always_comb begin
        locked = ((cur_loc == spipot_pkg::LOC_WIPER0 ||
                   cur_loc == spipot_pkg::LOC_NV_WIPER0) && wl0) ||
                 ((cur_loc == spipot_pkg::LOC_WIPER1 ||
                   cur_loc == spipot_pkg::LOC_NV_WIPER1) && wl1) ||
                 (is_nv(cur_loc) && cur_op == spipot_pkg::OP_WRITE && wp);
        next_value = mem[cur_loc];
        case (cur_op)
            spipot_pkg::OP_WRITE: next_value = {upper, shift[6:0], sdi_i};
            spipot_pkg::OP_INC: begin
                if (mem[cur_loc] < spipot_pkg::WIPER_FULL) begin
                    next_value = mem[cur_loc] + 9'h001;
                end
            end
            spipot_pkg::OP_DEC: begin
                if (mem[cur_loc] > spipot_pkg::WIPER_ZERO) begin
                    next_value = mem[cur_loc] - 9'h001;
                end
            end
            default: next_value = mem[cur_loc];
        endcase
    end

    always_ff @(posedge sck_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < 16; i++) begin
                mem[i] <= (i < 2) ? spipot_pkg::WIPER_RESET
                                  : spipot_pkg::MEM_RESET;
            end
        end else if (commit && !hv_op && !locked &&
                     cur_op != spipot_pkg::OP_READ) begin
            mem[cur_loc] <= next_value;
        end
    end

    always_ff @(posedge sck_i or posedge rst_i) begin
        if (rst_i) begin
            wl0 <= 1'b0;
            wl1 <= 1'b0;
            wp  <= 1'b0;
        end else if (commit && hv_op && cur_op != spipot_pkg::OP_READ &&
                     cur_op != spipot_pkg::OP_WRITE) begin
            case (cur_loc)
                spipot_pkg::LOC_NV_WIPER0:
                    wl0 <= (cur_op == spipot_pkg::OP_DEC);
                spipot_pkg::LOC_NV_WIPER1:
                    wl1 <= (cur_op == spipot_pkg::OP_DEC);
                default:
                    wp  <= (cur_op == spipot_pkg::OP_DEC);
            endcase
        end
    end

    always_ff @(posedge sck_i or posedge rst_i) begin
        if (rst_i) begin
            commit_tgl <= 1'b0;
            last_cmd   <= '0;
        end else if (commit) begin
            commit_tgl <= ~commit_tgl;
            last_cmd   <= '{location_field:  cur_loc,
                            operation_field: cur_op,
                            raised:          raised_select_level_i,
                            data:            (locked ? 9'h000 : 9'h1ff)};
        end
    end

    // ****************************************************************
    // Reference domain: crossings and outputs
    // ****************************************************************
    logic [2:0] tgl_sync;
    logic [1:0] sel_sync;
    logic [1:0] sck_sync;
    logic       sel_seen;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tgl_sync <= 3'h0;
            sel_sync <= 2'h0;
            sck_sync <= 2'h0;
            sel_seen <= 1'b0;
        end else begin
            tgl_sync <= {tgl_sync[1:0], commit_tgl};
            sel_sync <= {sel_sync[0], ~select_idle};
            sck_sync <= {sck_sync[0], sck_i};
            sel_seen <= sel_sync[1];
        end
    end

    // Output enable lags select by a few ref clocks
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sdo_oe_o   <= 1'b0;
            spi_mode_o <= 1'b0;
        end else begin
            sdo_oe_o <= sel_sync[1];
            if (sel_sync[1] && !sel_seen) begin
                spi_mode_o <= sck_sync[1];
            end
        end
    end

    // Link words are stable for at least eight serial clocks after toggle
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wiper0_o             <= spipot_pkg::WIPER_RESET;
            wiper1_o             <= spipot_pkg::WIPER_RESET;
            wiper0_protect_bit_o <= 1'b0;
            wiper1_protect_bit_o <= 1'b0;
            write_protect_o      <= 1'b0;
            nv_write_o           <= 1'b0;
            nv_write_addr_o      <= 4'h0;
        end else begin
            nv_write_o <= 1'b0;
            if (tgl_sync[2] != tgl_sync[1]) begin
                wiper0_o             <= mem[spipot_pkg::LOC_WIPER0];
                wiper1_o             <= mem[spipot_pkg::LOC_WIPER1];
                wiper0_protect_bit_o <= wl0;
                wiper1_protect_bit_o <= wl1;
                write_protect_o      <= wp;
                if (last_cmd.operation_field == spipot_pkg::OP_WRITE &&
                    is_nv(last_cmd.location_field) &&
                    last_cmd.data[0]) begin
                    nv_write_o      <= 1'b1;
                    nv_write_addr_o <= last_cmd.location_field;
                end
            end
        end
    end

endmodule // spipot_core

/* File: dv/spipot_core_sva.sv */
module spipot_core_sva (
    input wire logic       ref_clk_i,
    input wire logic       rst_i,
    input wire logic       select_n_i,
    input wire logic       raised_select_level_i,
    input wire logic       sdo_o,
    input wire logic       sdo_oe_o,
    input wire logic       spi_mode_o,
    input wire logic [8:0] wiper0_o,
    input wire logic [8:0] wiper1_o,
    input wire logic       wiper0_protect_bit_o,
    input wire logic       wiper1_protect_bit_o,
    input wire logic       write_protect_o,
    input wire logic       nv_write_o,
    input wire logic [3:0] nv_write_addr_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic       idle;
    logic [3:0] hv_age;

    assign idle = select_n_i && !raised_select_level_i;

    // Cycles since raised select was last seen, saturating
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hv_age <= 4'hf;
        end else if (raised_select_level_i) begin
            hv_age <= 4'h0;
        end else if (hv_age != 4'hf) begin
            hv_age <= hv_age + 4'h1;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence idle_run;
        idle [*4];
    endsequence
    sequence busy_run;
        !idle [*6];
    endsequence

    idle_out_a: assert property (idle_run |->
        sdo_o && !sdo_oe_o)
        else $error("serial output not parked while idle");
    oe_on_a: assert property ($fell(idle) |-> ##[2:4] sdo_oe_o)
        else $error("output enable late after select");
    mode_hold_a: assert property (busy_run |-> $stable(spi_mode_o))
        else $error("mode changed inside a frame");
    store_quiet_a: assert property (idle [*6] |->
        $stable(wiper0_o) && $stable(wiper1_o))
        else $error("wiper changed with select idle");
    prot_cause_a: assert property (
        ($changed(wiper0_protect_bit_o) ||
        $changed(wiper1_protect_bit_o) || $changed(write_protect_o))
        |-> hv_age < 4'h4) else $error("protection changed by normal frame");
    nv_pulse_a: assert property (nv_write_o |->
        nv_write_addr_o > 4'h1 && nv_write_addr_o != 4'h5 ##1 !nv_write_o)
        else $error("bad nonvolatile store pulse");
    wp_block_a: assert property (write_protect_o &&
        $past(write_protect_o) |-> !nv_write_o)
        else $error("store while write protected");
    lock_hold_a: assert property (wiper0_protect_bit_o &&
        $past(wiper0_protect_bit_o) |-> $stable(wiper0_o))
        else $error("locked wiper changed");
endmodule // spipot_core_sva

bind spipot_core spipot_core_sva chk_u (.ref_clk_i, .rst_i, .select_n_i,
    .raised_select_level_i, .sdo_o, .sdo_oe_o, .spi_mode_o, .wiper0_o,
    .wiper1_o, .wiper0_protect_bit_o, .wiper1_protect_bit_o,
    .write_protect_o, .nv_write_o, .nv_write_addr_o);

/* File: dv/spipot_master_model.sv */
module spipot_master_model (
    input  wire logic        ref_clk_i,
    input  wire logic        sdo_i,
    output logic             sck_o,
    output logic             sdi_o,
    output logic             select_n_o,
    output logic             raised_o,
    output logic             done_o,
    output logic [15:0]      miso_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sck_o = 1'b0;
        sdi_o = 1'b0;
        select_n_o = 1'b1;
        raised_o = 1'b0;
        done_o = 1'b0;
        miso_o = 16'h0;
    end

    // 125 ns link period keeps well under the 10 MHz ceiling
    // Split data pins, so the shared-pin read limit never applies
    task automatic frame(input logic md, input logic hv, input int n,
                         input logic [15:0] b);
        sck_o = md;
        repeat (3) @(negedge ref_clk_i);
        select_n_o = hv;
        raised_o = hv;
        repeat (5) @(negedge ref_clk_i);
        miso_o = 16'h0;
        for (int i = 0; i < n; i++) begin
            sck_o = 1'b0;
            sdi_o = b[15 - i];
            #62.5;
            miso_o = {miso_o[14:0], sdo_i};
            sck_o = 1'b1;
            #62.5;
        end
        sck_o = md;
        sdi_o = ~sdi_o; // No stale bit left on a released line
        repeat (5) @(negedge ref_clk_i);
        select_n_o = 1'b1;
        raised_o = 1'b0;
        done_o = 1'b1;
        @(negedge ref_clk_i);
        done_o = 1'b0;
    endtask
endmodule // spipot_master_model

/* File: dv/test_spi_pot_command_interface.sv */
module test_spi_pot_command_interface;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic [15:0] miso;
        logic [15:0] mask;
        logic [8:0]  w0;
        logic [8:0]  w1;
        logic [2:0]  prot;
        logic        md;
    } spipot_note_t;

    logic         ref_clk, rst, sck, sdi, sel_n, hv, sdo, oe, mode;
    logic         p0, p1, wp, nvw, done;
    logic [8:0]   w0, w1, rd;
    logic [3:0]   nva;
    logic [15:0]  miso;
    int           bad_count, n_tests, cycles, nv_count;
    spipot_note_t notes[$];
    spipot_note_t nt;

    spipot_core dut_u (.ref_clk_i(ref_clk), .rst_i(rst), .sck_i(sck),
        .sdi_i(sdi), .select_n_i(sel_n), .raised_select_level_i(hv),
        .sdo_o(sdo), .sdo_oe_o(oe), .spi_mode_o(mode), .wiper0_o(w0),
        .wiper1_o(w1), .wiper0_protect_bit_o(p0), .wiper1_protect_bit_o(p1),
        .write_protect_o(wp), .nv_write_o(nvw), .nv_write_addr_o(nva));
    spipot_master_model pm_u (.ref_clk_i(ref_clk), .sdo_i(sdo), .sck_o(sck),
        .sdi_o(sdi), .select_n_o(sel_n), .raised_o(hv), .done_o(done),
        .miso_o(miso));

    initial ref_clk = 1'b0;
    always #20 ref_clk = ~ref_clk;

    task automatic check(input string nm, input logic [15:0] e, g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Note the expectation, then let the master run the frame
    task automatic run(input logic md, h, input int n, input logic [15:0] b,
                       e, input logic [8:0] e0, e1, input logic [2:0] ep);
        notes.push_back({e, 16'hffff >> (16 - n), e0, e1, ep, md});
        pm_u.frame(md, h, n, b);
        repeat (10) @(negedge ref_clk);
    endtask

    always @(posedge done) begin
        if (notes.size() == 0) begin
            bad_count++;
            $display("wrong value notes expected 1 seen 0");
        end else begin
            nt = notes.pop_front();
            check("miso", nt.miso, miso & nt.mask);
            check("wiper0", {7'h0, nt.w0}, {7'h0, w0});
            check("wiper1", {7'h0, nt.w1}, {7'h0, w1});
            check("prot", {13'h0, nt.prot}, {13'h0, wp, p1, p0});
            check("mode", {15'h0, nt.md}, {15'h0, mode});
        end
    end

    // Store pulses counted away from the launching edge
    always @(negedge ref_clk) begin
        if (nvw === 1'b1) begin
            nv_count++;
        end
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles > 20000) begin
            bad_count++;
            end_sim();
        end
    end

    initial begin
        rst = 1'b1;
        void'($urandom(32'h6bfbc44f));
        repeat (10) @(negedge ref_clk);
        rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        run(0, 0, 16, 16'h0155, 16'hffff, 9'h155, 9'h080, 0);
        run(1, 0, 16, 16'h0c00, 16'hff55, 9'h155, 9'h080, 0);
        run(0, 0, 8, 16'h1400, 16'h00ff, 9'h155, 9'h081, 0);
        run(1, 0, 8, 16'h1800, 16'h00ff, 9'h155, 9'h080, 0);
        run(0, 0, 8, 16'h6400, 16'h00fd, 9'h155, 9'h080, 0);
        run(0, 0, 16, 16'h6404, 16'hfdfd, 9'h155, 9'h080, 0);
        run(0, 0, 12, 16'h10aa, 16'h0fff, 9'h155, 9'h080, 0);
        run(0, 1, 8, 16'h2800, 16'h00ff, 9'h155, 9'h080, 1);
        run(0, 0, 16, 16'h0000, 16'hffff, 9'h155, 9'h080, 1);
        run(1, 1, 8, 16'h2400, 16'h00ff, 9'h155, 9'h080, 0);
        run(0, 1, 16, 16'h38f8, 16'hffff, 9'h155, 9'h080, 6);
        run(0, 0, 16, 16'h60a5, 16'hffff, 9'h155, 9'h080, 6);
        run(0, 1, 16, 16'h34f4, 16'hffff, 9'h155, 9'h080, 0);
        run(0, 0, 16, 16'h60a5, 16'hffff, 9'h155, 9'h080, 0);
        repeat (50) @(negedge ref_clk);
        check("nv_addr", 16'h0006, {12'h0, nva});
        run(0, 0, 16, 16'h5c00, 16'hfe00, 9'h155, 9'h080, 0);
        run(0, 0, 16, 16'h5000, 16'hfdff, 9'h155, 9'h080, 0);
        for (int i = 0; i < 4; i++) begin
            rd = 9'($urandom % 257);
            run(rd[0], 0, 16, {7'h08, rd}, 16'hffff, 9'h155, rd, 0);
            run(rd[1], 0, 16, 16'h1c00, {7'h7f, rd}, 9'h155, rd, 0);
        end
        check("nv_pulses", 16'h0001, 16'(nv_count));
        end_sim();
    end
endmodule // test_spi_pot_command_interface
